// File: rtl/dwsl_loader.sv
// Serial input, latch and open-drain output logic of a two-channel wiper.
// Assumes chip select and serial data change with the serial clock, which
// may stand still outside frames; preset and power-down are free pins.
`timescale 1ns/1ps
`include "dwsl_params.svh"

module dwsl_loader
  import dwsl_pkg::*;
(
  // System clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Serial link from the host
  input  wire logic                  sclk_i,
  input  wire logic                  cs_n_i,
  input  wire logic                  serial_in_i,
  output logic                       serial_out_o,
  output logic                       serial_out_oe_n_o,
  // Control pins
  input  wire logic                  preset_to_mid_n_i,
  input  wire logic                  power_down_n_i,
  // Wiper latches and analog switch controls
  output dwsl_code_t                 wiper_latch_first_o,
  output dwsl_code_t                 wiper_latch_second_o,
  output logic [`DWSL_TAPS-1:0]      tap_first_o,
  output logic [`DWSL_TAPS-1:0]      tap_second_o,
  output logic                       terminal_a_open_o,
  output logic                       wiper_to_b_o
);

  // --------------------------------------------------------------------------
  // Link domain: shift register and output latch on the serial clock
  // --------------------------------------------------------------------------
  logic [`DWSL_WORD_BITS-1:0] input_shift_reg;
  logic [`DWSL_WORD_BITS-1:0] input_shift_next;
  logic                       sdo_latch_reg;
  logic                       sdo_latch_next;
  logic                       shift_toggle_reg;
  logic                       shift_toggle_next;
  logic                       link_preset_meta_reg;
  logic                       link_preset_sync_reg;
  logic                       link_pd_meta_reg;
  logic                       link_pd_sync_reg;
  logic                       shift_en;

  // Preset and power-down are free pins, so the link side sees them late.
  assign shift_en = ~cs_n_i & link_preset_sync_reg & link_pd_sync_reg;

  always_comb begin
    input_shift_next  = input_shift_reg;
    sdo_latch_next    = sdo_latch_reg;
    shift_toggle_next = shift_toggle_reg;
    if (!link_preset_sync_reg) begin
      sdo_latch_next = 1'b0;
    end else if (shift_en) begin
      // The oldest bit falls off, so only the last nine survive a frame.
      input_shift_next  = {input_shift_reg[`DWSL_WORD_BITS-2:0], serial_in_i};
      sdo_latch_next    = input_shift_reg[`DWSL_OUT_DELAY-1];
      shift_toggle_next = ~shift_toggle_reg;
    end
  end

  always_ff @(posedge sclk_i or posedge rst_i) begin
    if (rst_i) begin
      input_shift_reg      <= '0;
      sdo_latch_reg        <= 1'b0;
      shift_toggle_reg     <= 1'b0;
      link_preset_meta_reg <= 1'b1;
      link_preset_sync_reg <= 1'b1;
      link_pd_meta_reg     <= 1'b1;
      link_pd_sync_reg     <= 1'b1;
    end else begin
      input_shift_reg      <= input_shift_next;
      sdo_latch_reg        <= sdo_latch_next;
      shift_toggle_reg     <= shift_toggle_next;
      link_preset_meta_reg <= preset_to_mid_n_i;
      link_preset_sync_reg <= link_preset_meta_reg;
      link_pd_meta_reg     <= power_down_n_i;
      link_pd_sync_reg     <= link_pd_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Crossing into the system clock
  // --------------------------------------------------------------------------
  // The word is quiet while chip select is high, so two stages suffice once
  // the load waits two more edges than the chip select synchroniser.
  logic       cs_meta_reg;
  logic       cs_sync_reg;
  logic       cs_d1_reg;
  logic       cs_d2_reg;
  logic       pre_meta_reg;
  logic       pre_sync_reg;
  logic       pd_meta_reg;
  logic       pd_sync_reg;
  logic       sdo_meta_reg;
  logic       sdo_sync_reg;
  logic       tog_meta_reg;
  logic       tog_sync_reg;
  logic       tog_prev_reg;
  dwsl_word_s word_meta_reg;
  dwsl_word_s word_sync_reg;
  logic       cs_rise;
  logic       shift_seen;
  logic       preset_active;
  logic       power_down;

  assign cs_rise       = cs_d1_reg & ~cs_d2_reg;
  assign shift_seen    = tog_sync_reg ^ tog_prev_reg;
  assign preset_active = ~pre_sync_reg;
  assign power_down    = ~pd_sync_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cs_meta_reg   <= 1'b1;
      cs_sync_reg   <= 1'b1;
      cs_d1_reg     <= 1'b1;
      cs_d2_reg     <= 1'b1;
      pre_meta_reg  <= 1'b1;
      pre_sync_reg  <= 1'b1;
      pd_meta_reg   <= 1'b1;
      pd_sync_reg   <= 1'b1;
      sdo_meta_reg  <= 1'b0;
      sdo_sync_reg  <= 1'b0;
      tog_meta_reg  <= 1'b0;
      tog_sync_reg  <= 1'b0;
      tog_prev_reg  <= 1'b0;
      word_meta_reg <= '0;
      word_sync_reg <= '0;
    end else begin
      cs_meta_reg   <= cs_n_i;
      cs_sync_reg   <= cs_meta_reg;
      cs_d1_reg     <= cs_sync_reg;
      cs_d2_reg     <= cs_d1_reg;
      pre_meta_reg  <= preset_to_mid_n_i;
      pre_sync_reg  <= pre_meta_reg;
      pd_meta_reg   <= power_down_n_i;
      pd_sync_reg   <= pd_meta_reg;
      sdo_meta_reg  <= sdo_latch_reg;
      sdo_sync_reg  <= sdo_meta_reg;
      tog_meta_reg  <= shift_toggle_reg;
      tog_sync_reg  <= tog_meta_reg;
      tog_prev_reg  <= tog_sync_reg;
      word_meta_reg <= dwsl_word_s'(input_shift_reg);
      word_sync_reg <= word_meta_reg;
    end
  end

  // --------------------------------------------------------------------------
  // Wiper latches
  // --------------------------------------------------------------------------
  function automatic dwsl_code_t latch_next_value(
    input dwsl_code_t    cur,
    input logic          preset,
    input logic          load,
    input dwsl_word_s    word,
    input dwsl_channel_e ch
  );
    dwsl_code_t val;
    val = cur;
    if (preset) begin
      val = `DWSL_MIDSCALE;
    end else if (load && word.channel_select_bit == ch) begin
      val = word.data;
    end
    return val;
  endfunction

  // Unpacked so that each channel's processes own separate elements.
  dwsl_code_t                 wiper_reg  [`DWSL_CHANNELS];
  dwsl_code_t                 wiper_next [`DWSL_CHANNELS];
  logic [`DWSL_TAPS-1:0]      tap_bus    [`DWSL_CHANNELS];

  genvar ch_g;
  generate
    for (ch_g = 0; ch_g < `DWSL_CHANNELS; ch_g++) begin : g_channel
      always_comb begin
        wiper_next[ch_g] = latch_next_value(wiper_reg[ch_g], preset_active, cs_rise,
                                            word_sync_reg, dwsl_channel_e'(ch_g));
      end

      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          wiper_reg[ch_g] <= `DWSL_MIDSCALE;
        end else begin
          wiper_reg[ch_g] <= wiper_next[ch_g];
        end
      end

      dwsl_tap_decoder #(
        .TAPS     (`DWSL_TAPS)
      ) u_tap (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .code_i   (wiper_reg[ch_g]),
        .tap_on_o (tap_bus[ch_g])
      );
    end
  endgenerate

  assign wiper_latch_first_o  = wiper_reg[DWSL_CH_FIRST];
  assign wiper_latch_second_o = wiper_reg[DWSL_CH_SECOND];
  assign tap_first_o          = tap_bus[DWSL_CH_FIRST];
  assign tap_second_o         = tap_bus[DWSL_CH_SECOND];

  // --------------------------------------------------------------------------
  // Open-drain output and power-down controls
  // --------------------------------------------------------------------------
  logic sdo_clear_reg;
  logic sdo_clear_next;
  logic oe_n_reg;
  logic oe_n_next;
  logic a_open_reg;
  logic a_open_next;

  always_comb begin
    sdo_clear_next = sdo_clear_reg;
    if (preset_active) begin
      sdo_clear_next = 1'b1;
    end else if (shift_seen) begin
      sdo_clear_next = 1'b0;
    end
    a_open_next = power_down;
    // Only a zero bit pulls the line; a one is left to the pull-up.
    oe_n_next = 1'b1;
    if (!power_down && !cs_sync_reg) begin
      oe_n_next = sdo_clear_reg | sdo_sync_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sdo_clear_reg <= 1'b1;
      oe_n_reg      <= 1'b1;
      a_open_reg    <= 1'b0;
    end else begin
      sdo_clear_reg <= sdo_clear_next;
      oe_n_reg      <= oe_n_next;
      a_open_reg    <= a_open_next;
    end
  end

  assign serial_out_o      = 1'b0;
  assign serial_out_oe_n_o = oe_n_reg;
  assign terminal_a_open_o = a_open_reg;
  assign wiper_to_b_o      = a_open_reg;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  sequence load_first_seq;
    cs_rise && !preset_active && word_sync_reg.channel_select_bit == DWSL_CH_FIRST;
  endsequence

  sequence load_second_seq;
    cs_rise && !preset_active && word_sync_reg.channel_select_bit == DWSL_CH_SECOND;
  endsequence

  shift_order_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    shift_en && link_preset_sync_reg |=>
      input_shift_reg == {$past(input_shift_reg[`DWSL_WORD_BITS-2:0]), $past(serial_in_i)}
  ) else $error("shift register did not take the serial bit at the bottom");

  idle_hold_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    !shift_en |=> $stable(input_shift_reg)
  ) else $error("shift register changed without a shifting edge");

  out_delay_a: assert property (
    @(posedge sclk_i) disable iff (rst_i)
    shift_en ##1 shift_en [*8] |=> sdo_latch_reg == $past(serial_in_i, 9)
  ) else $error("serial output bit is not the one entered eight edges earlier");

  load_first_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    load_first_seq |=> wiper_reg[0] == $past(word_sync_reg.data) && $stable(wiper_reg[1])
  ) else $error("first latch load wrong or second latch disturbed");

  load_second_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    load_second_seq |=> wiper_reg[1] == $past(word_sync_reg.data) && $stable(wiper_reg[0])
  ) else $error("second latch load wrong or first latch disturbed");

  preset_mid_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !preset_to_mid_n_i [*4] |=>
      wiper_reg[0] == `DWSL_MIDSCALE && wiper_reg[1] == `DWSL_MIDSCALE && serial_out_oe_n_o
  ) else $error("preset did not force midscale and clear the output");

  preset_wins_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    cs_rise && preset_active |=> wiper_reg[0] == `DWSL_MIDSCALE && wiper_reg[1] == `DWSL_MIDSCALE
  ) else $error("chip select load beat an active preset");

  power_on_mid_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $past(rst_i) |-> wiper_reg[0] == `DWSL_MIDSCALE && wiper_reg[1] == `DWSL_MIDSCALE
  ) else $error("latches not at midscale after power-on");

  down_hold_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    power_down && !preset_active && !cs_rise |=> $stable(wiper_reg[0]) && $stable(wiper_reg[1])
  ) else $error("latch contents changed during power-down");

  down_release_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !power_down_n_i [*3] |=> serial_out_oe_n_o && terminal_a_open_o && wiper_to_b_o
  ) else $error("power-down did not open A, tie wiper to B and release output");

  drive_frame_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    !serial_out_oe_n_o |-> !$past(cs_sync_reg) && $past(pd_sync_reg) && serial_out_o == 1'b0
  ) else $error("serial output driven outside an active frame or driven high");

endmodule

// File: rtl/dwsl_tap_decoder.sv
// One-hot tap decoder for a single wiper channel.
// Assumes the code input comes from a register on the same clock.
`timescale 1ns/1ps
`include "dwsl_params.svh"

module dwsl_tap_decoder
  import dwsl_pkg::*;
#(
  parameter int TAPS = `DWSL_TAPS
) (
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  // Latch value in, tap switches out
  input  wire dwsl_code_t      code_i,
  output logic [TAPS-1:0]      tap_on_o
);

  localparam logic [TAPS-1:0] TAP_RESET = {{(TAPS-1){1'b0}}, 1'b1} << `DWSL_MID_INDEX;

  logic [TAPS-1:0] tap_next;

  always_comb begin
    tap_next = '0;
    tap_next[code_i] = 1'b1;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tap_on_o <= TAP_RESET;
    end else begin
      tap_on_o <= tap_next;
    end
  end

  tap_one_hot_a: assert property (
    @(posedge clk_i) disable iff (rst_i)
    $onehot(tap_on_o) && tap_on_o[$past(code_i)] == 1'b1 || $past(rst_i)
  ) else $error("tap switches not one-hot at the latch code");

endmodule

// File: shared/dwsl_params.svh
// Constants of the dual wiper serial loader: word layout, latch values, tap count.
// Assumes inclusion by its bare name from the package and the design modules.
// Contract
// - Nine-bit word: channel bit, then data MSB-first.
// - Channel bit 0 first latch, 1 second.
// - Shift one bit per rising serial clock.
// - Output bit entered eight positions earlier.
// - Idle clock keeps register, enables output; the code releases the output while select is high.
// - Only last nine shifted bits are kept.
// - Chip select rise loads selected latch only.
// - Preset low forces midscale, clears output.
// - Preset rise with select high holds midscale.
// - Power-on presets both latches to midscale.
// - Power-down opens A, wiper to B, releases output.
// - Power-down keeps latch contents unchanged; the code still loads the selected latch on a chip select rise.
// - Output is open-drain: pull low or release.
// - One of 256 taps on at a time.
`ifndef DWSL_PARAMS_SVH
`define DWSL_PARAMS_SVH

// ----------------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------------
`define DWSL_WORD_BITS 9
`define DWSL_DATA_BITS 8
`define DWSL_SEL_POS   8
`define DWSL_OUT_DELAY 8

// ----------------------------------------------------------------------------
// Latch values and channel count
// ----------------------------------------------------------------------------
`define DWSL_MIDSCALE  8'h80
`define DWSL_MID_INDEX 128
`define DWSL_TAPS      256
`define DWSL_CHANNELS  2

`endif

// File: shared/dwsl_pkg.sv
// Types shared by the dual wiper serial loader modules.
// Assumes dwsl_params.svh is on the include path.
`include "dwsl_params.svh"

package dwsl_pkg;

  // --------------------------------------------------------------------------
  // Channel select encoding
  // --------------------------------------------------------------------------
  typedef enum logic {
    DWSL_CH_FIRST  = 1'b0,
    DWSL_CH_SECOND = 1'b1
  } dwsl_channel_e;

  // --------------------------------------------------------------------------
  // Serial word as it sits in the shift register, first bit highest
  // --------------------------------------------------------------------------
  typedef struct packed {
    dwsl_channel_e                  channel_select_bit;
    logic [`DWSL_DATA_BITS-1:0]     data;
  } dwsl_word_s;

  typedef logic [`DWSL_DATA_BITS-1:0] dwsl_code_t;

endpackage

// File: tb/dwsl_host_model.sv
// Host side of the serial link: drives select, link clock and data in frames.
// Assumes the bench calls the frame tasks; the link clock stands low between frames.
`timescale 1ns/1ps

module dwsl_host_model (
  // Serial link towards the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic serial_in_o
);
  initial begin
    sclk_o      = 1'b0;
    cs_n_o      = 1'b1;
    serial_in_o = 1'b0;
  end

  task automatic open_frame;
    cs_n_o = 1'b0;
    #23;
  endtask

  // Sends the lowest n bits of v, highest of them first, at 30 ns per bit.
  task automatic shift(input logic [17:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in_o = v[i];
      #15 sclk_o = 1'b1;
      #15 sclk_o = 1'b0;
    end
  endtask

  // Data is inverted after release so a stale bit never looks valid.
  task automatic close_frame;
    #40 cs_n_o = 1'b1;
    serial_in_o = ~serial_in_o;
  endtask
endmodule

// File: tb/dwsl_loader_test.sv
// Self-checking bench of the dual wiper serial loader.
// Assumes the shared package and the host model are compiled first.
`timescale 1ns/1ps

module dwsl_loader_test;
  import dwsl_pkg::*;
  logic         clk_i             = 1'b0;
  logic         rst_i             = 1'b1;
  logic         preset_to_mid_n_i = 1'b1;
  logic         power_down_n_i    = 1'b1;
  logic         sclk;
  logic         cs_n;
  logic         sdata;
  logic         sdo_val;
  logic         sdo_oe_n;
  logic         a_open;
  logic         w_to_b;
  logic         sdo_line;
  dwsl_code_t   lat1;
  dwsl_code_t   lat2;
  dwsl_code_t   seen1;
  dwsl_code_t   seen2;
  dwsl_code_t   cur1;
  dwsl_code_t   cur2;
  logic [255:0] tap1;
  logic [255:0] tap2;
  logic [15:0]  exp_q[$];
  int           mismatches = 0;
  int           n_tests    = 0;

  always #10 clk_i = ~clk_i;

  // The pull-up supplies the high level whenever the device releases the line.
  assign sdo_line = sdo_oe_n ? 1'b1 : sdo_val;

  dwsl_host_model i_dwsl_host_model (
    .sclk_o      (sclk),
    .cs_n_o      (cs_n),
    .serial_in_o (sdata)
  );

  dwsl_loader i_dwsl_loader (
    .clk_i                (clk_i),
    .rst_i                (rst_i),
    .sclk_i               (sclk),
    .cs_n_i               (cs_n),
    .serial_in_i          (sdata),
    .serial_out_o         (sdo_val),
    .serial_out_oe_n_o    (sdo_oe_n),
    .preset_to_mid_n_i    (preset_to_mid_n_i),
    .power_down_n_i       (power_down_n_i),
    .wiper_latch_first_o  (lat1),
    .wiper_latch_second_o (lat2),
    .tap_first_o          (tap1),
    .tap_second_o         (tap2),
    .terminal_a_open_o    (a_open),
    .wiper_to_b_o         (w_to_b)
  );

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic bump(input logic ok, input string what);
    n_tests++;
    if (!ok) begin
      mismatches++;
      $display("[ERR] %0t %s", $time, what);
    end
  endtask

  task automatic check_latch(input logic [15:0] e);
    bump({lat1, lat2} === e, "wiper latch pair differs");
  endtask

  task automatic check_line(input logic e);
    bump(sdo_line === e, "serial output line differs");
  endtask

  task automatic check_taps(input dwsl_code_t e1, input dwsl_code_t e2);
    bump(tap1 === (256'h1 << e1) && tap2 === (256'h1 << e2), "tap vector differs");
  endtask

  task automatic check_pd(input logic e);
    bump({a_open, w_to_b} === {e, e}, "power-down controls differ");
  endtask

  // Loads a fresh code into one channel; n bits of the frame are sent.
  task automatic load(input logic ch, input int n, input logic chk);
    dwsl_code_t  d;
    logic [17:0] v;
    d = (ch ? cur2 : cur1) ^ (8'h01 | 8'($urandom));
    if (ch) begin
      cur2 = d;
    end else begin
      cur1 = d;
    end
    exp_q.push_back({cur1, cur2});
    v = {9'($urandom), ch, d};
    i_dwsl_host_model.open_frame();
    i_dwsl_host_model.shift(v, n);
    if (chk) begin
      repeat (6) @(posedge clk_i);
      check_line(ch);
    end
    i_dwsl_host_model.close_frame();
    repeat (8) @(posedge clk_i);
  endtask

  // Each latch change takes the oldest note; taps follow the latch one edge later.
  always @(posedge clk_i) begin
    #1;
    if (!rst_i) begin
      check_taps(seen1, seen2);
    end
    if (!rst_i && {lat1, lat2} !== {seen1, seen2}) begin
      if (exp_q.size() == 0) begin
        bump(1'b0, "latch changed without cause");
      end else begin
        check_latch(exp_q.pop_front());
      end
    end
    {seen1, seen2} = {lat1, lat2};
  end

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hBD5AD767));
    {cur1, cur2} = 16'h8080;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    check_latch(16'h8080);
    for (int i = 0; i < 4; i++) begin
      load(i[0], 9, 1'b0);
    end
    for (int i = 0; i < 2; i++) begin
      load(!i[0], 18, 1'b1);
    end
    power_down_n_i <= 1'b0;
    // The open frame holds a zero output bit, so only power-down releases the line.
    i_dwsl_host_model.open_frame();
    repeat (6) @(posedge clk_i);
    check_pd(1'b1);
    check_line(1'b1);
    i_dwsl_host_model.close_frame();
    repeat (8) @(posedge clk_i);
    power_down_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check_pd(1'b0);
    check_latch({cur1, cur2});
    preset_to_mid_n_i <= 1'b0;
    if ({cur1, cur2} != 16'h8080) begin
      exp_q.push_back(16'h8080);
    end
    {cur1, cur2} = 16'h8080;
    repeat (6) @(posedge clk_i);
    check_latch(16'h8080);
    i_dwsl_host_model.open_frame();
    i_dwsl_host_model.shift(18'h0AB, 9);
    i_dwsl_host_model.close_frame();
    repeat (8) @(posedge clk_i);
    preset_to_mid_n_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    check_latch(16'h8080);
    load(1'b1, 11, 1'b0);
    load(1'b0, 11, 1'b0);
    bump(exp_q.size() == 0, "expected latch change never seen");
    end_of_test();
  end
endmodule
